// ---- rtl/civ_top.sv ----
// interrupt and exception entry sequencer: picks a source at an instruction
// boundary, pushes flags, clears the enable and trap bits, pushes code segment
// and return offset, reads the four-byte vector and hands the new target over.
// assumes the core stalls while busy_o is high and raises boundary_i only
// in the last clock of an instruction; the stack pointer it sees is current.

// How it works
// - table of 256 entries at 0..3FFH
// - entry holds two words: segment and offset
// - software events first, maskable and step last
// - entry clears enable and trap bits
// - entry takes 61,50,51,52,53 clocks per class
// - taken at boundaries; save segment, offset, flags
// - divide overflow raises type 0 always
// - trap bit gives type 1 one instruction later
// - step ignores the enable bit
// - nmi edge, synchronised, two clocks guaranteed, type 2
// - recognised nmi edge is remembered
// - breakpoint instruction gives unmaskable type 3
// - overflow trap type 4 only with overflow_flag
// - 0,1,3,4 from instructions; 2 from pin
// - table address is type times four
// - push flags, clear bits, push segment, offset
// - maskable level synchronised, honoured only when enabled
module civ_top (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic maskable_irq_in_i,
   input wire logic nmi_pin_i,
   input wire logic boundary_i,
   input wire logic div_err_i,
   input wire logic swi_i,
   input wire logic [7:0] swi_type_i,
   input wire logic brk_i,
   input wire logic into_i,
   input wire logic [7:0] ext_type_i,
   input wire logic [15:0] flags_i,
   input wire logic [15:0] cs_i,
   input wire logic [15:0] instr_pointer_reg_i,
   input wire logic [15:0] ss_i,
   input wire logic [15:0] sp_i,
   output logic accept_o,
   output logic busy_o,
   output logic [7:0] type_o,
   output logic load_o,
   output logic [15:0] cs_o,
   output logic [15:0] instr_pointer_reg_o,
   output logic [15:0] flags_o,
   output logic flags_we_o,
   output logic [15:0] sp_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [19:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      civ_pkg::civ_state_t st;
      civ_pkg::civ_cls_t cls;
      logic [7:0] typ;
      logic [5:0] cnt;
      logic trap_prev;
      logic issued;
      logic acc;
      logic load;
      logic fwe;
      logic [15:0] fsv;
      logic [15:0] fl_out;
      logic [15:0] seg;
      logic [15:0] spv;
      logic [15:0] rcs;
      logic [15:0] rofs;
      logic [15:0] new_ofs;
      logic [15:0] new_cs;
   } civ_top_t;
   civ_top_t s, n;

   civ_acc_if acc_bus ();
   logic irq_lvl;
   logic nmi_pend;
   logic nmi_take;
   logic sw_hit;
   logic ovf_hit;
   logic ext_hit;
   logic any_hit;

   // ----------------------------------------
   // pins and memory port
   // ----------------------------------------
   civ_pin_sync u_sync (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .nmi_pin_i(nmi_pin_i),
      .irq_pin_i(maskable_irq_in_i),
      .nmi_take_i(nmi_take),
      .irq_lvl_o(irq_lvl),
      .nmi_pend_o(nmi_pend)
   );

   civ_mem_port u_port (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .acc(acc_bus.slave),
      .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o),
      .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i)
   );

   // ----------------------------------------
   // source qualification
   // ----------------------------------------
   assign ovf_hit = into_i && flags_i[civ_pkg::OVF_FLAG_BIT];
   assign sw_hit = div_err_i || swi_i || brk_i || ovf_hit;
   assign ext_hit = irq_lvl && flags_i[civ_pkg::IEN_FLAG_BIT];
   assign any_hit = sw_hit || nmi_pend || ext_hit || s.trap_prev;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      n = s;
      n.acc = 1'b0;
      n.load = 1'b0;
      n.fwe = 1'b0;
      nmi_take = 1'b0;
      acc_bus.req = 1'b0;
      acc_bus.we = 1'b0;
      acc_bus.addr = civ_pkg::stk_addr(s.seg, s.spv - civ_pkg::STK_STEP);
      acc_bus.wdata = s.fsv;
      if (s.st != civ_pkg::ST_IDLE && s.cnt != '1) begin
         n.cnt = s.cnt + 6'h01;
      end
      case (s.st)
         civ_pkg::ST_IDLE: begin
            // sources are looked at only in an instruction's last clock
            if (boundary_i) begin
               n.trap_prev = flags_i[civ_pkg::TRAP_FLAG_BIT];
               if (any_hit) begin
                  n.st = civ_pkg::ST_PSH_F;
                  n.acc = 1'b1;
                  n.cnt = 6'h01;
                  n.issued = 1'b0;
                  n.fsv = flags_i;
                  n.seg = ss_i;
                  n.spv = sp_i;
                  n.rcs = cs_i;
                  n.rofs = instr_pointer_reg_i;
                  // handler's first instruction runs with the trap bit clear
                  n.trap_prev = 1'b0;
                  if (div_err_i) begin
                     n.cls = civ_pkg::CL_DIV;
                     n.typ = civ_pkg::TY_DIV;
                  end else if (swi_i) begin
                     n.cls = civ_pkg::CL_SWI;
                     n.typ = swi_type_i;
                  end else if (brk_i) begin
                     n.cls = civ_pkg::CL_BRK;
                     n.typ = civ_pkg::TY_BRK;
                  end else if (ovf_hit) begin
                     n.cls = civ_pkg::CL_OVF;
                     n.typ = civ_pkg::TY_OVF;
                  end else if (nmi_pend) begin
                     n.cls = civ_pkg::CL_NMI;
                     n.typ = civ_pkg::TY_NMI;
                     nmi_take = 1'b1;
                  end else if (ext_hit) begin
                     n.cls = civ_pkg::CL_EXT;
                     n.typ = ext_type_i;
                  end else begin
                     n.cls = civ_pkg::CL_STEP;
                     n.typ = civ_pkg::TY_STEP;
                  end
               end
            end
         end
         civ_pkg::ST_PSH_F: begin
            acc_bus.req = !s.issued;
            acc_bus.we = 1'b1;
            n.issued = 1'b1;
            if (acc_bus.done) begin
               n.spv = s.spv - civ_pkg::STK_STEP;
               n.issued = 1'b0;
               n.st = civ_pkg::ST_CLR;
            end
         end
         civ_pkg::ST_CLR: begin
            n.fwe = 1'b1;
            n.fl_out = s.fsv;
            n.fl_out[civ_pkg::IEN_FLAG_BIT] = 1'b0;
            n.fl_out[civ_pkg::TRAP_FLAG_BIT] = 1'b0;
            n.st = civ_pkg::ST_PSH_C;
         end
         civ_pkg::ST_PSH_C: begin
            acc_bus.req = !s.issued;
            acc_bus.we = 1'b1;
            acc_bus.wdata = s.rcs;
            n.issued = 1'b1;
            if (acc_bus.done) begin
               n.spv = s.spv - civ_pkg::STK_STEP;
               n.issued = 1'b0;
               n.st = civ_pkg::ST_PSH_RET;
            end
         end
         civ_pkg::ST_PSH_RET: begin
            acc_bus.req = !s.issued;
            acc_bus.we = 1'b1;
            acc_bus.wdata = s.rofs;
            n.issued = 1'b1;
            if (acc_bus.done) begin
               n.spv = s.spv - civ_pkg::STK_STEP;
               n.issued = 1'b0;
               n.st = civ_pkg::ST_RD_OFS;
            end
         end
         civ_pkg::ST_RD_OFS: begin
            acc_bus.req = !s.issued;
            acc_bus.addr = civ_pkg::vec_addr(s.typ);
            n.issued = 1'b1;
            if (acc_bus.done) begin
               n.new_ofs = acc_bus.rdata;
               n.issued = 1'b0;
               n.st = civ_pkg::ST_RD_CS;
            end
         end
         civ_pkg::ST_RD_CS: begin
            acc_bus.req = !s.issued;
            acc_bus.addr = civ_pkg::vec_addr(s.typ) + civ_pkg::CS_OFS;
            n.issued = 1'b1;
            if (acc_bus.done) begin
               n.new_cs = acc_bus.rdata;
               n.issued = 1'b0;
               n.st = civ_pkg::ST_HOLD;
            end
         end
         civ_pkg::ST_HOLD: begin
            // pads to the class time; slow memory can only lengthen it
            if (s.cnt >= civ_pkg::entry_clks(s.cls) - 6'h01) begin
               n.load = 1'b1;
               n.st = civ_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = civ_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign accept_o = s.acc;
   assign busy_o = s.st != civ_pkg::ST_IDLE;
   assign type_o = s.typ;
   assign load_o = s.load;
   assign cs_o = s.new_cs;
   assign instr_pointer_reg_o = s.new_ofs;
   assign flags_o = s.fl_out;
   assign flags_we_o = s.fwe;
   assign sp_o = s.spv;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   vec_range_a: assert property (
      acc_bus.req && s.st == civ_pkg::ST_RD_OFS |-> acc_bus.addr <= civ_pkg::VEC_TOP - 20'h3)
      else $error("vector read outside the table");
   vec_scale_a: assert property (
      acc_bus.req && s.st == civ_pkg::ST_RD_OFS |-> acc_bus.addr == {10'h000, s.typ, 2'h0})
      else $error("vector address is not type times four");
   cs_word_a: assert property (
      acc_bus.req && s.st == civ_pkg::ST_RD_CS
      |-> acc_bus.addr == $past(mem_addr_o) + civ_pkg::CS_OFS)
      else $error("segment word not two bytes above offset word");
   flags_clear_a: assert property (
      flags_we_o |-> !flags_o[civ_pkg::IEN_FLAG_BIT] && !flags_o[civ_pkg::TRAP_FLAG_BIT])
      else $error("enable or trap bit left set on entry");
   push_order_a: assert property (
      s.st == civ_pkg::ST_CLR |-> $past(s.st) == civ_pkg::ST_PSH_F ##1
      flags_we_o && s.st == civ_pkg::ST_PSH_C)
      else $error("flags not cleared between flag push and segment push");
   entry_time_a: assert property (
      load_o |-> s.cnt >= civ_pkg::entry_clks(s.cls) && $past(busy_o))
      else $error("entry finished before its class time");
   boundary_only_a: assert property (
      accept_o |-> $past(boundary_i) && !$past(busy_o))
      else $error("entry started off an instruction boundary");
   sw_first_a: assert property (
      boundary_i && !busy_o && sw_hit |=> accept_o && s.cls inside
      {civ_pkg::CL_DIV, civ_pkg::CL_SWI, civ_pkg::CL_BRK, civ_pkg::CL_OVF})
      else $error("software event lost to a hardware source");
   div_uncond_a: assert property (
      boundary_i && !busy_o && div_err_i |=> accept_o && s.typ == civ_pkg::TY_DIV)
      else $error("divide error not raised");
   step_free_a: assert property (
      boundary_i && !busy_o && s.trap_prev && !sw_hit && !nmi_pend && !ext_hit
      |=> accept_o && s.typ == civ_pkg::TY_STEP)
      else $error("single step not taken");
   mask_gate_a: assert property (
      accept_o && s.cls == civ_pkg::CL_EXT |-> $past(flags_i[civ_pkg::IEN_FLAG_BIT]))
      else $error("maskable request taken while disabled");
   ovf_gate_a: assert property (
      accept_o && s.cls == civ_pkg::CL_OVF |-> $past(flags_i[civ_pkg::OVF_FLAG_BIT]))
      else $error("overflow trap without overflow_flag");
   nmi_src_a: assert property (
      accept_o && s.cls == civ_pkg::CL_NMI |-> $past(nmi_pend) && !$past(sw_hit))
      else $error("type 2 without a pending pin edge");
endmodule

// ---- rtl/civ_pkg.sv ----
// constants, types and decode helpers of the interrupt vectoring unit
// assumes 20-bit physical addresses, 16-bit words and an 8-bit type number
package civ_pkg;
   // ----------------------------------------
   // widths and vector table
   // ----------------------------------------
   localparam int ADDR_W = 32'h14;
   localparam int WORD_W = 32'h10;
   localparam int TYPE_W = 32'h8;
   localparam int CNT_W = 32'h6;
   localparam int VEC_ENTRIES = 32'h100;
   localparam logic [19:0] VEC_TOP = 20'h003FF;
   localparam int VEC_SHIFT = 32'h2;
   localparam int SEG_SHIFT = 32'h4;
   localparam logic [19:0] CS_OFS = 20'h00002;
   localparam logic [15:0] STK_STEP = 16'h0002;
   // ----------------------------------------
   // predefined types and flag positions
   // ----------------------------------------
   localparam logic [7:0] TY_DIV = 8'h00;
   localparam logic [7:0] TY_STEP = 8'h01;
   localparam logic [7:0] TY_NMI = 8'h02;
   localparam logic [7:0] TY_BRK = 8'h03;
   localparam logic [7:0] TY_OVF = 8'h04;
   localparam int TRAP_FLAG_BIT = 32'h8;
   localparam int IEN_FLAG_BIT = 32'h9;
   localparam int OVF_FLAG_BIT = 32'hB;
   localparam int PIN_IRQ = 32'h0;
   localparam int PIN_NMI = 32'h1;
   // ----------------------------------------
   // entry times in clocks
   // ----------------------------------------
   localparam logic [5:0] CLK_EXT = 6'h3D;
   localparam logic [5:0] CLK_NMI = 6'h32;
   localparam logic [5:0] CLK_SWI = 6'h33;
   localparam logic [5:0] CLK_BRK = 6'h34;
   localparam logic [5:0] CLK_OVF = 6'h35;
   localparam logic [5:0] CLK_STEP = 6'h32;
   localparam logic [5:0] CLK_DIV = 6'h33;
   typedef enum logic [2:0] {
      CL_DIV, CL_SWI, CL_BRK, CL_OVF, CL_NMI, CL_EXT, CL_STEP
   } civ_cls_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_PSH_F = 3'h1, ST_CLR = 3'h3, ST_PSH_C = 3'h2,
      ST_PSH_RET = 3'h6, ST_RD_OFS = 3'h7, ST_RD_CS = 3'h5, ST_HOLD = 3'h4
   } civ_state_t;
   function automatic logic [5:0] entry_clks(input civ_cls_t c);
      case (c)
         CL_EXT: entry_clks = CLK_EXT;
         CL_NMI: entry_clks = CLK_NMI;
         CL_SWI: entry_clks = CLK_SWI;
         CL_BRK: entry_clks = CLK_BRK;
         CL_OVF: entry_clks = CLK_OVF;
         CL_STEP: entry_clks = CLK_STEP;
         default: entry_clks = CLK_DIV;
      endcase
   endfunction
   function automatic logic [19:0] vec_addr(input logic [7:0] ty);
      vec_addr = 20'(ty) << VEC_SHIFT;
   endfunction
   function automatic logic [19:0] stk_addr(input logic [15:0] seg, input logic [15:0] ofs);
      stk_addr = (20'(seg) << SEG_SHIFT) + 20'(ofs);
   endfunction
endpackage

// ---- rtl/civ_acc_if.sv ----
// one word access between the sequencer and the memory port
// assumes one request in flight; req is a one-cycle pulse
interface civ_acc_if;
   logic req;
   logic we;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport master (output req, output we, output addr, output wdata, input done, input rdata);
   modport slave (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

// ---- rtl/civ_pin_sync.sv ----
// synchronisers for the two request pins and the held non-maskable edge
// assumes both pins are asynchronous to core_clk_i
module civ_pin_sync (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic nmi_pin_i,
   input wire logic irq_pin_i,
   input wire logic nmi_take_i,
   output logic irq_lvl_o,
   output logic nmi_pend_o
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] lvl;
      logic pend;
   } civ_sync_t;
   civ_sync_t s_r, s_nxt;

   // ----------------------------------------
   // filter and edge memory
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = {nmi_pin_i, irq_pin_i};
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // a change counts only once two stages agree, so one-cycle glitches die here
      for (int i = 0; i < 2; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.lvl[i] = s_r.s2[i];
         end
      end
      if (nmi_take_i) begin
         s_nxt.pend = 1'b0;
      end
      // set wins over take, so an edge in the take cycle is kept
      if (s_nxt.lvl[civ_pkg::PIN_NMI] && !s_r.lvl[civ_pkg::PIN_NMI]) begin
         s_nxt.pend = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign irq_lvl_o = s_r.lvl[civ_pkg::PIN_IRQ];
   assign nmi_pend_o = s_r.pend;

   nmi_two_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      !nmi_pin_i ##1 nmi_pin_i [*2] ##1 !nmi_take_i [*4] |-> ##[1:4] nmi_pend_o)
      else $error("two-cycle nmi pulse not recognised");
   nmi_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      nmi_pend_o && !nmi_take_i |=> nmi_pend_o)
      else $error("pending nmi lost before it was taken");
endmodule

// ---- rtl/civ_mem_port.sv ----
// single word memory port for stack pushes and vector reads
// assumes memory holds mem_ack_i high for one cycle per access
module civ_mem_port (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   civ_acc_if.slave acc,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [19:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i
);
   typedef struct packed {
      logic busy;
      logic we;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic done;
   } civ_port_t;
   civ_port_t p_r, p_nxt;

   always_comb begin
      p_nxt = p_r;
      p_nxt.done = 1'b0;
      if (!p_r.busy && acc.req) begin
         p_nxt.busy = 1'b1;
         p_nxt.we = acc.we;
         p_nxt.addr = acc.addr;
         p_nxt.wdata = acc.wdata;
      end else if (p_r.busy && mem_ack_i) begin
         p_nxt.busy = 1'b0;
         p_nxt.done = 1'b1;
         p_nxt.rdata = mem_rdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         p_r <= '0;
      end else begin
         p_r <= p_nxt;
      end
   end

   assign mem_req_o = p_r.busy;
   assign mem_we_o = p_r.we;
   assign mem_addr_o = p_r.addr;
   assign mem_wdata_o = p_r.wdata;
   assign acc.done = p_r.done;
   assign acc.rdata = p_r.rdata;

   word_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("word access changed before acknowledge");
endmodule

// ---- dv/civ_mem_model.sv ----
// word memory standing in for the stack and the vector table
// assumes one access at a time, req held until the cycle after ack
module civ_mem_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [19:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [1:0] stall_i,
   output logic ack_o,
   output logic [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // storage, unwritten words read as an address pattern
   // ----
   logic [15:0] ram [logic [19:0]];
   logic [1:0] wait_r;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         wait_r <= 2'h0;
         rdata_o <= 16'h0000;
      end else begin
         ack_o <= 1'b0;
         // junk outside the ack cycle, so a late sample is caught
         rdata_o <= ~rdata_o;
         if (req_i && !ack_o) begin
            if (wait_r != stall_i) begin
               wait_r <= wait_r + 2'h1;
            end else begin
               wait_r <= 2'h0;
               ack_o <= 1'b1;
               if (we_i) ram[addr_i] = wdata_i;
               rdata_o <= ram.exists(addr_i) ? ram[addr_i] : addr_i[15:0] ^ 16'hC35A;
            end
         end
      end
   end
endmodule

// ---- dv/test_cpu_interrupt_vectoring.sv ----
// self-checking bench of the interrupt entry sequencer
// assumes a core that raises boundary_i for one clock and memory in civ_mem_model
`define civ_chk(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module test_cpu_interrupt_vectoring;
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // stimulus and wiring
   // ----
   logic clk, rstn, irq, nmi, bnd, div, swi, brk, into, accept, busy, load, fl_we;
   logic mreq, mwe, mack;
   logic [7:0] swt, ext, ty;
   logic [15:0] fl, cs, ipr, ss, sp, cs_n, ip_n, fl_n, sp_n, mwd, mrd;
   logic [19:0] maddr;
   logic [1:0] stall;
   logic [31:0] seed;
   int miscompares, tests_run, cyc;
   civ_top dut (.core_clk_i(clk), .rstn_i(rstn), .maskable_irq_in_i(irq), .nmi_pin_i(nmi),
      .boundary_i(bnd), .div_err_i(div), .swi_i(swi), .swi_type_i(swt), .brk_i(brk),
      .into_i(into), .ext_type_i(ext), .flags_i(fl), .cs_i(cs), .instr_pointer_reg_i(ipr),
      .ss_i(ss), .sp_i(sp), .accept_o(accept), .busy_o(busy), .type_o(ty), .load_o(load),
      .cs_o(cs_n), .instr_pointer_reg_o(ip_n), .flags_o(fl_n), .flags_we_o(fl_we),
      .sp_o(sp_n), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr),
      .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd));
   civ_mem_model mem (.clk_i(clk), .rstn_i(rstn), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
      .wdata_i(mwd), .stall_i(stall), .ack_o(mack), .rdata_o(mrd));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] vw(input logic [19:0] a);
      vw = a[15:0] ^ 16'hC35A;
   endfunction
   task automatic tally_and_finish;
      if (miscompares == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one boundary with sources src = {div, swi, brk, into}; expectation from priority order
   task automatic go(input logic [3:0] src, input logic [15:0] f, input logic [7:0] st,
                     input bit pend, input bit stp);
      logic [7:0] t;
      logic [15:0] q, s;
      logic [19:0] b;
      int c, n, nw;
      seed = lfsr(seed);
      q = {2'h1, seed[29:16]};
      s = seed[31:16] | 16'h0010;
      b = {q, 4'h0} + {4'h0, s};
      t = seed[23:16];
      c = 0;
      if (src[3]) begin
         t = 8'h00;
         c = 51;
      end else if (src[2]) begin
         t = st;
         c = 51;
      end else if (src[1]) begin
         t = 8'h03;
         c = 52;
      end else if (src[0] && f[11]) begin
         t = 8'h04;
         c = 53;
      end else if (pend) begin
         t = 8'h02;
         c = 50;
      end else if (irq && f[9]) begin
         c = 61;
      end else if (stp) begin
         t = 8'h01;
         c = 50;
      end
      @(posedge clk);
      bnd <= 1'b1;
      {div, swi, brk, into} <= src;
      swt <= st;
      ext <= seed[23:16];
      fl <= f;
      cs <= seed[15:0];
      ipr <= ~seed[15:0];
      ss <= q;
      sp <= s;
      @(posedge clk);
      bnd <= 1'b0;
      {div, swi, brk, into} <= 4'h0;
      #1;
      if (c == 0) begin
         `civ_chk("idle", 1'b0, accept)
      end else begin
         `civ_chk("accept", 1'b1, accept)
         `civ_chk("busy", 1'b1, busy)
         `civ_chk("type", t, ty)
         n = 1;
         nw = 0;
         while (load !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
            if (fl_we === 1'b1) nw++;
         end
         if (stall == 2'h0) `civ_chk("clocks", c, n)
         `civ_chk("busy_end", 1'b0, busy)
         `civ_chk("flags_we", 1, nw)
         `civ_chk("flags", f & 16'hFCFF, fl_n)
         `civ_chk("vec_ip", vw({10'h000, t, 2'h0}), ip_n)
         `civ_chk("vec_cs", vw({10'h000, t, 2'h2}), cs_n)
         `civ_chk("sp", s - 16'h0006, sp_n)
         `civ_chk("push_fl", f, mem.ram[b - 20'h2])
         `civ_chk("push_cs", seed[15:0], mem.ram[b - 20'h4])
         `civ_chk("push_ip", ~seed[15:0], mem.ram[b - 20'h6])
      end
   endtask
   // ----
   // clock, watchdog and scenarios
   // ----
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   initial begin
      {rstn, irq, nmi, bnd, div, swi, brk, into} = 8'h00;
      {swt, ext, fl, cs, ipr, ss, sp, stall} = 0;
      seed = 32'h0000023C;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      // trap bit with enable clear: silent boundary, step, silent again, step
      go(4'h0, 16'h0100, 8'h20, 0, 0);
      go(4'h0, 16'h0100, 8'h20, 0, 1);
      go(4'h0, 16'h0100, 8'h20, 0, 0);
      go(4'h0, 16'h0100, 8'h20, 0, 1);
      // two-clock pin pulse, withdrawn long before the boundary
      @(posedge clk);
      nmi <= 1'b1;
      repeat (2) @(posedge clk);
      nmi <= 1'b0;
      repeat (8) @(posedge clk);
      go(4'h0, 16'h0200, 8'h20, 1, 0);
      @(posedge clk);
      irq <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         @(posedge clk);
         stall <= seed[9:8];
         if (i == 0) go(4'hF, seed[31:16] & 16'hFEFF, 8'h20, 0, 0);
         else if (i == 1) go(4'h4, 16'h0000, 8'hFF, 0, 0);
         else if (i == 2) go(4'h1, 16'h0800, 8'h20, 0, 0);
         else if (i == 3) go(4'h1, 16'h0000, 8'h20, 0, 0);
         else go(seed[3:0] & seed[7:4], seed[31:16] & 16'hFEFF,
                 8'(32 + seed[15:8] % 224), 0, 0);
      end
      tally_and_finish;
   end
endmodule
